// [hdl/pin_change_interrupt.sv]
// pin-change interrupt logic for port A (8 bits) and port B (7 bits, bit 3 not implemented)
`include "pin_change_params.svh"
`timescale 1ns/1ps
`default_nettype none
module pin_change_interrupt
	import pin_change_pkg::*;
(
	input  wire logic                 sys_clk_i,
	input  wire logic                 srst_i,
	input  wire logic                 master_clear_rst_i,
	input  wire logic                 master_clear_pin_cfg_i,
	input  wire logic                 sleep_i,
	input  wire logic [7:0]           port_a_pins_i,
	input  wire logic [7:0]           port_b_pins_i,
	input  wire logic [7:0]           port_a_analog_select_i,
	input  wire logic [7:0]           port_b_analog_select_i,
	input  wire logic [`PC_ADDR_W-1:0] addr_i,
	input  wire logic [7:0]           wdata_i,
	input  wire logic                 wr_i,
	input  wire logic                 rd_i,
	output logic      [7:0]           rdata_o,
	output logic                      change_irq_o,
	output logic                      wake_o,
	output logic                      irq_o
);
	// =========================================================
	// state
	pc_state_t s_q;
	pc_state_t s_d;
	byte_t     live_a;
	byte_t     live_b;
	logic      mismatch;
	logic      port_access;
	logic      wr_ctrl;
	logic      clr_flag;
	logic [1:0] ev_set;

	// =========================================================
	// detection
	always_comb begin
		live_a = s_q.en_a & ~port_a_analog_select_i;
		live_b = s_q.en_b & ~port_b_analog_select_i & `PC_B_IMPL_MASK;
		// master-clear pin out of detection
		// pin 5 masked
		if (master_clear_pin_cfg_i) begin
			live_a[`PC_MASTER_CLEAR_PIN] = 1'b0;
		end
		mismatch = |(((s_q.sync2_a ^ s_q.latch_a) & live_a)
			| ((s_q.sync2_b ^ s_q.latch_b) & live_b));
		port_access = (rd_i || wr_i) && (addr_i == `PC_OFS_PORT_A
			|| addr_i == `PC_OFS_PORT_B);
		wr_ctrl = wr_i && addr_i == `PC_OFS_INT_CTRL;
		clr_flag = wr_ctrl && !wdata_i[`PC_BIT_FLAG];
	end

	// =========================================================
	// next state
	always_comb begin
		s_d = s_q;
		ev_set = 2'b00;
		s_d.sync1_a = port_a_pins_i;
		s_d.sync1_b = port_b_pins_i;
		s_d.sync2_a = s_q.sync1_a;
		s_d.sync2_b = s_q.sync1_b;
		if (port_access) begin
			s_d.latch_a = s_q.sync2_a;
			s_d.latch_b = s_q.sync2_b;
		end
		s_d.rdata = 8'h00;
		if (rd_i) begin
			unique case (addr_i)
			`PC_OFS_A_ENABLE:   s_d.rdata = s_q.en_a;
			`PC_OFS_B_ENABLE:   s_d.rdata = s_q.en_b;
			`PC_OFS_INT_CTRL: begin
				s_d.rdata[`PC_BIT_FLAG]   = s_q.flag;
				s_d.rdata[`PC_BIT_IRQ_EN] = s_q.irq_en;
			end
			`PC_OFS_PORT_A:     s_d.rdata = s_q.sync2_a;
			`PC_OFS_PORT_B:     s_d.rdata = s_q.sync2_b & `PC_B_IMPL_MASK;
			`PC_OFS_IRQ_STATUS: s_d.rdata = {6'h00, s_q.ev_status};
			`PC_OFS_IRQ_ENABLE: s_d.rdata = {6'h00, s_q.ev_enable};
			default:            s_d.rdata = 8'h00;
			endcase
		end
		if (wr_i) begin
			unique case (addr_i)
			`PC_OFS_A_ENABLE: s_d.en_a = wdata_i;
			`PC_OFS_B_ENABLE: s_d.en_b = wdata_i & `PC_B_IMPL_MASK;
			`PC_OFS_INT_CTRL: s_d.irq_en = wdata_i[`PC_BIT_IRQ_EN];
			`PC_OFS_IRQ_ENABLE: s_d.ev_enable = wdata_i[1:0];
			default: ;
			endcase
		end
		if (clr_flag) begin
			s_d.flag = 1'b0;
		end
		if (mismatch) begin
			s_d.flag = 1'b1;
		end
		s_d.wake = mismatch && s_q.irq_en && sleep_i;
		ev_set[`PC_EV_FLAG_SET] = mismatch && !s_q.flag;
		ev_set[`PC_EV_WAKE] = s_d.wake && !s_q.wake;
		if (wr_i && addr_i == `PC_OFS_IRQ_CLEAR) begin
			s_d.ev_status = s_q.ev_status & ~wdata_i[1:0];
		end
		s_d.ev_status = s_d.ev_status | ev_set;
		// master clear keeps copy and enables, clears irq_en and events, reloads flag from mismatch
		if (master_clear_rst_i) begin
			s_d.flag      = mismatch;
			s_d.irq_en    = 1'b0;
			s_d.ev_status = 2'b00;
			s_d.ev_enable = 2'b00;
			s_d.wake      = 1'b0;
		end
	end

	// =========================================================
	// registers
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			s_q <= '0;
			s_q.en_a <= `PC_RST_ENABLE;
			s_q.en_b <= `PC_RST_ENABLE;
		end else begin
			s_q <= s_d;
		end
	end

	assign rdata_o = s_q.rdata;
	assign change_irq_o = s_q.flag && s_q.irq_en;
	assign wake_o = s_q.wake;
	assign irq_o = |(s_q.ev_status & s_q.ev_enable);

	// =========================================================
	// checks
	sequence mis_seen;
		mismatch && !master_clear_rst_i;
	endsequence

	flag_on_mismatch_a: assert property (
		@(posedge sys_clk_i) disable iff (srst_i)
		mis_seen |=> s_q.flag)
		else $error("mismatch did not set flag");
	clear_loses_a: assert property (
		@(posedge sys_clk_i) disable iff (srst_i)
		(clr_flag && mismatch) |=> s_q.flag)
		else $error("clear beat mismatch");
	irq_gate_a: assert property (
		@(posedge sys_clk_i) disable iff (srst_i)
		(mis_seen and s_q.irq_en && !wr_ctrl) |=> change_irq_o)
		else $error("no irq with enable set");
	irq_off_a: assert property (
		@(posedge sys_clk_i) disable iff (srst_i)
		!s_q.irq_en |-> !change_irq_o)
		else $error("irq without enable");
	flag_holds_a: assert property (
		@(posedge sys_clk_i) disable iff (srst_i)
		(s_q.flag && !clr_flag && !master_clear_rst_i) |=> s_q.flag)
		else $error("flag cleared by itself");
	flag_quiet_a: assert property (
		@(posedge sys_clk_i) disable iff (srst_i)
		(!s_q.flag && !mismatch) |=> !s_q.flag)
		else $error("flag set without mismatch");
	copy_keep_a: assert property (
		@(posedge sys_clk_i) disable iff (srst_i)
		!port_access |=> ($stable(s_q.latch_a) && $stable(s_q.latch_b)))
		else $error("copy moved without port access");
	master_clear_flag_a: assert property (
		@(posedge sys_clk_i) disable iff (srst_i)
		master_clear_rst_i |=> s_q.flag == $past(mismatch))
		else $error("flag not reloaded on master clear");
	wake_gate_a: assert property (
		@(posedge sys_clk_i) disable iff (srst_i)
		!s_q.irq_en |=> !wake_o)
		else $error("wake without enable");
	a_write_a: assert property (
		@(posedge sys_clk_i) disable iff (srst_i)
		(wr_i && addr_i == `PC_OFS_A_ENABLE) |=> s_q.en_a == $past(wdata_i))
		else $error("port a enable write lost");
	b_read_bit3_a: assert property (
		@(posedge sys_clk_i) disable iff (srst_i)
		(rd_i && addr_i == `PC_OFS_B_ENABLE) |=> !rdata_o[3])
		else $error("port b bit 3 read as one");
	rdata_idle_a: assert property (
		@(posedge sys_clk_i) disable iff (srst_i)
		!rd_i |=> rdata_o == 8'h00)
		else $error("read data without read");
	ev_sticky_a: assert property (
		@(posedge sys_clk_i) disable iff (srst_i)
		(s_q.ev_status[`PC_EV_FLAG_SET] && !master_clear_rst_i
			&& !(wr_i && addr_i == `PC_OFS_IRQ_CLEAR))
		|=> s_q.ev_status[`PC_EV_FLAG_SET])
		else $error("event status lost");
	reset_enables_a: assert property (
		@(posedge sys_clk_i)
		srst_i |=> (s_q.en_a == 8'h00 && s_q.en_b == 8'h00))
		else $error("enables not cleared");
	b_bit3_zero_a: assert property (
		@(posedge sys_clk_i) disable iff (srst_i)
		!s_q.en_b[3])
		else $error("port b bit 3 set");
	copy_refresh_a: assert property (
		@(posedge sys_clk_i) disable iff (srst_i)
		port_access |=> s_q.latch_a == $past(s_q.sync2_a))
		else $error("copy not refreshed");
	master_clear_pin_mask_a: assert property (
		@(posedge sys_clk_i) disable iff (srst_i)
		master_clear_pin_cfg_i |-> !live_a[`PC_MASTER_CLEAR_PIN])
		else $error("master clear pin detecting");
	wake_follows_a: assert property (
		@(posedge sys_clk_i) disable iff (srst_i)
		(mis_seen and s_q.irq_en && sleep_i) |=> wake_o)
		else $error("no wake");
	master_clear_copy_a: assert property (
		@(posedge sys_clk_i) disable iff (srst_i)
		(master_clear_rst_i && !port_access) |=> $stable(s_q.latch_a))
		else $error("copy lost on master clear");
endmodule
`default_nettype wire

// [hdl/pin_change_params.svh]
// offsets, field positions and reset values of the pin-change block
`ifndef PIN_CHANGE_PARAMS_SVH
`define PIN_CHANGE_PARAMS_SVH
`define PC_ADDR_W          4
`define PC_OFS_A_ENABLE    4'h0
`define PC_OFS_B_ENABLE    4'h1
`define PC_OFS_INT_CTRL    4'h2
`define PC_OFS_PORT_A      4'h3
`define PC_OFS_PORT_B      4'h4
`define PC_OFS_IRQ_STATUS  4'h5
`define PC_OFS_IRQ_CLEAR   4'h6
`define PC_OFS_IRQ_ENABLE  4'h7
`define PC_BIT_FLAG        0
`define PC_BIT_IRQ_EN      3
`define PC_B_IMPL_MASK     8'hf7
`define PC_MASTER_CLEAR_PIN        5
`define PC_RST_ENABLE      8'h00
`define PC_RST_INT_CTRL    8'h00
`define PC_EV_FLAG_SET     0
`define PC_EV_WAKE         1
`endif

// [hdl/pin_change_pkg.sv]
// types of the pin-change block
package pin_change_pkg;
	typedef logic [7:0] byte_t;
	typedef struct packed {
		byte_t       sync1_a;
		byte_t       sync1_b;
		byte_t       sync2_a;
		byte_t       sync2_b;
		byte_t       latch_a;
		byte_t       latch_b;
		byte_t       en_a;
		byte_t       en_b;
		logic        flag;
		logic        irq_en;
		logic [1:0]  ev_status;
		logic [1:0]  ev_enable;
		byte_t       rdata;
		logic        wake;
	} pc_state_t;
endpackage

// [bench/pin_model.sv]
// far-side pin drivers for the pin-change bench
`timescale 1ns/1ps
`default_nettype none
module pin_model (
	input  wire logic       sys_clk_i,
	input  wire logic [7:0] set_a_i,
	input  wire logic [7:0] set_b_i,
	output logic      [7:0] pin_a_o,
	output logic      [7:0] pin_b_o
);
	// pins move just after an edge, never during a port access
	always_ff @(posedge sys_clk_i) begin
		pin_a_o <= set_a_i;
		pin_b_o <= set_b_i;
	end
endmodule
`default_nettype wire

// [bench/pin_change_interrupt_tb.sv]
// self-checking bench of the pin-change block
`include "pin_change_params.svh"
`timescale 1ns/1ps
`default_nettype none
module pin_change_interrupt_tb;
	import pin_change_pkg::*;
	logic       clk = 0, srst = 1, mrst = 0, mcfg = 0, slp = 0;
	logic       wr = 0, rd = 0, cirq, wake, irq;
	logic [3:0] addr = 0;
	byte_t      wd = 0, pa = 0, pb = 0, anb = 0;
	byte_t      pin_a, pin_b, rdata, v;
	int         n_errors = 0, checked = 0;
	always #2.5 clk = ~clk;
	pin_model pm (.sys_clk_i(clk), .set_a_i(pa), .set_b_i(pb),
		.pin_a_o(pin_a), .pin_b_o(pin_b));
	pin_change_interrupt dut (.sys_clk_i(clk), .srst_i(srst),
		.master_clear_rst_i(mrst), .master_clear_pin_cfg_i(mcfg), .sleep_i(slp),
		.port_a_pins_i(pin_a), .port_b_pins_i(pin_b),
		.port_a_analog_select_i(8'h00), .port_b_analog_select_i(anb),
		.addr_i(addr), .wdata_i(wd), .wr_i(wr), .rd_i(rd),
		.rdata_o(rdata), .change_irq_o(cirq), .wake_o(wake), .irq_o(irq));
	task automatic chk(input byte_t got, input byte_t exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wreg(input logic [3:0] a, input byte_t d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wd <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [3:0] a);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask
	task automatic rc(input logic [3:0] a, input byte_t exp);
		rreg(a);
		chk(v, exp);
	endtask
	// move the pins, then allow sync and detection to settle
	task automatic pins(input byte_t a, input byte_t b);
		@(posedge clk);
		pa <= a;
		pb <= b;
		repeat (6) @(posedge clk);
		#1;
	endtask
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		#20000;
		n_errors++;
		wrap_up();
	end
	initial begin
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		rc(`PC_OFS_A_ENABLE, 8'h00);
		rc(`PC_OFS_B_ENABLE, 8'h00);
		wreg(`PC_OFS_A_ENABLE, 8'hff);
		wreg(`PC_OFS_B_ENABLE, 8'hff);
		rc(`PC_OFS_A_ENABLE, 8'hff);
		rc(`PC_OFS_B_ENABLE, 8'hf7);
		rc(4'h8, 8'h00);
		rreg(`PC_OFS_PORT_A);
		wreg(`PC_OFS_INT_CTRL, 8'h00);
		pins(8'h01, 8'h00);
		rc(`PC_OFS_INT_CTRL, 8'h01);
		chk({7'h0, cirq}, 8'h00);
		wreg(`PC_OFS_INT_CTRL, 8'h09);
		#1 chk({7'h0, cirq}, 8'h01);
		wreg(`PC_OFS_INT_CTRL, 8'h08);
		rc(`PC_OFS_INT_CTRL, 8'h09);
		rreg(`PC_OFS_PORT_A);
		wreg(`PC_OFS_INT_CTRL, 8'h08);
		rc(`PC_OFS_INT_CTRL, 8'h08);
		pins(8'h01, 8'h01);
		rc(`PC_OFS_INT_CTRL, 8'h09);
		wreg(`PC_OFS_PORT_B, 8'h00);
		wreg(`PC_OFS_INT_CTRL, 8'h08);
		rc(`PC_OFS_INT_CTRL, 8'h08);
		// disabled, master-clear and analog pins stay silent
		@(posedge clk);
		mcfg <= 1'b1;
		anb <= 8'h02;
		wreg(`PC_OFS_A_ENABLE, 8'hfe);
		pins(8'h20, 8'h03);
		rc(`PC_OFS_INT_CTRL, 8'h08);
		@(posedge clk);
		slp <= 1'b1;
		wreg(`PC_OFS_IRQ_ENABLE, 8'h03);
		pins(8'h22, 8'h03);
		chk({7'h0, wake}, 8'h01);
		rc(`PC_OFS_IRQ_STATUS, 8'h03);
		chk({7'h0, irq}, 8'h01);
		@(posedge clk);
		slp <= 1'b0;
		wreg(`PC_OFS_IRQ_ENABLE, 8'h00);
		#1 chk({7'h0, irq}, 8'h00);
		rreg(`PC_OFS_PORT_A);
		wreg(`PC_OFS_INT_CTRL, 8'h08);
		wreg(`PC_OFS_IRQ_CLEAR, 8'h03);
		rc(`PC_OFS_IRQ_STATUS, 8'h00);
		pins(8'h26, 8'h03);
		@(posedge clk);
		mrst <= 1'b1;
		@(posedge clk);
		mrst <= 1'b0;
		repeat (4) @(posedge clk);
		rc(`PC_OFS_INT_CTRL, 8'h01);
		// copy kept over master clear: no mismatch, no flag
		rreg(`PC_OFS_PORT_A);
		wreg(`PC_OFS_INT_CTRL, 8'h00);
		@(posedge clk);
		mrst <= 1'b1;
		@(posedge clk);
		mrst <= 1'b0;
		repeat (4) @(posedge clk);
		rc(`PC_OFS_INT_CTRL, 8'h00);
		wrap_up();
	end
endmodule
`default_nettype wire
